/* File: common/idw_pkg.sv */
// Package for the identify parameter block, words 50 to 82.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package idw_pkg;

    // Register byte offsets
    localparam logic [7:0] IDW_OFS_CTRL   = 8'h00;
    localparam logic [7:0] IDW_OFS_DATA   = 8'h04;
    localparam logic [7:0] IDW_OFS_CYL    = 8'h08;
    localparam logic [7:0] IDW_OFS_HEAD   = 8'h0c;
    localparam logic [7:0] IDW_OFS_SPT    = 8'h10;
    localparam logic [7:0] IDW_OFS_CAP    = 8'h14;
    localparam logic [7:0] IDW_OFS_MULT   = 8'h18;
    localparam logic [7:0] IDW_OFS_LBA    = 8'h1c;
    localparam logic [7:0] IDW_OFS_DMA    = 8'h20;
    localparam logic [7:0] IDW_OFS_PIO    = 8'h24;
    localparam logic [7:0] IDW_OFS_DMAT   = 8'h28;
    localparam logic [7:0] IDW_OFS_PIOT   = 8'h2c;
    localparam logic [7:0] IDW_OFS_QDEP   = 8'h30;
    localparam logic [7:0] IDW_OFS_VER    = 8'h34;
    localparam logic [7:0] IDW_OFS_FEAT   = 8'h38;
    localparam logic [7:0] IDW_OFS_VALID  = 8'h3c;

    // Control and status bit positions at IDW_OFS_CTRL
    localparam int IDW_CTRL_START = 0;
    localparam int IDW_STAT_BUSY  = 0;
    localparam int IDW_STAT_DRQ   = 1;
    localparam int IDW_STAT_INTRQ = 2;

    // Span of the parameter block held here
    localparam logic [7:0] IDW_FIRST_WORD = 8'd50;
    localparam logic [7:0] IDW_LAST_WORD  = 8'd82;
    localparam int         IDW_NWORDS     = 33;

    // Word numbers with content
    localparam logic [7:0] IDW_W_VALID = 8'd53;
    localparam logic [7:0] IDW_W_CYL   = 8'd54;
    localparam logic [7:0] IDW_W_HEAD  = 8'd55;
    localparam logic [7:0] IDW_W_SPT   = 8'd56;
    localparam logic [7:0] IDW_W_CAPLO = 8'd57;
    localparam logic [7:0] IDW_W_CAPHI = 8'd58;
    localparam logic [7:0] IDW_W_MULT  = 8'd59;
    localparam logic [7:0] IDW_W_LBALO = 8'd60;
    localparam logic [7:0] IDW_W_LBAHI = 8'd61;
    localparam logic [7:0] IDW_W_DMA   = 8'd63;
    localparam logic [7:0] IDW_W_PIO   = 8'd64;
    localparam logic [7:0] IDW_W_DMAMN = 8'd65;
    localparam logic [7:0] IDW_W_DMARC = 8'd66;
    localparam logic [7:0] IDW_W_PIOMN = 8'd67;
    localparam logic [7:0] IDW_W_PIORD = 8'd68;
    localparam logic [7:0] IDW_W_QDEP  = 8'd75;
    localparam logic [7:0] IDW_W_MAJOR = 8'd80;
    localparam logic [7:0] IDW_W_MINOR = 8'd81;
    localparam logic [7:0] IDW_W_FEAT  = 8'd82;

    // Field layouts
    localparam int IDW_MULT_VALID_BIT = 8;
    localparam int IDW_DMA_SEL_LSB    = 8;
    localparam int IDW_DMA_SEL_W      = 3;
    localparam int IDW_DMA_SUP_W      = 3;
    localparam int IDW_VALID_W        = 3;
    localparam int IDW_QDEP_W         = 5;
    localparam int IDW_MAJOR_LSB      = 2;
    localparam int IDW_MAJOR_W        = 4;

    // Bits of word 82 that may be reported; 15, 11 and 4 stay zero
    localparam logic [15:0] IDW_FEAT_MASK = 16'h77ef;

    // Reset values of the configuration registers
    localparam logic [31:0] IDW_RST_ZERO = 32'h0000_0000;

endpackage

/* File: verilog/idw_word_mux.sv */
// Combinational builder of one identify parameter word from its number.
// Assumes the configuration fields come from registers of the same clock.
`timescale 1ns/1ns
module idw_word_mux
    import idw_pkg::*;
(
    input  wire logic [7:0]  word_num,
    input  wire logic [15:0] cyl,
    input  wire logic [15:0] head,
    input  wire logic [15:0] spt,
    input  wire logic [31:0] cap,
    input  wire logic [8:0]  mult,
    input  wire logic [31:0] lba,
    input  wire logic [2:0]  dma_sel,
    input  wire logic [2:0]  dma_sup,
    input  wire logic [7:0]  pio,
    input  wire logic [31:0] dma_times,
    input  wire logic [31:0] pio_times,
    input  wire logic [4:0]  qdepth,
    input  wire logic [3:0]  major,
    input  wire logic [15:0] minor,
    input  wire logic [15:0] feat,
    input  wire logic [2:0]  valid,
    output logic      [15:0] word
);

    // Keeps only the highest requested DMA mode so a single one shows selected
    function automatic logic [2:0] one_mode(input logic [2:0] req);
        if (req[2])      one_mode = 3'h4;
        else if (req[1]) one_mode = 3'h2;
        else             one_mode = {2'h0, req[0]};
    endfunction

    wire logic [2:0] sel_one = one_mode(dma_sel);

    // Unlisted numbers, reserved and obsolete words, read as zero
    always_comb begin
        word = 16'h0000;
        case (word_num)
            IDW_W_VALID: word = {13'h0000, valid};
            IDW_W_CYL:   word = cyl;
            IDW_W_HEAD:  word = head;
            IDW_W_SPT:   word = spt;
            IDW_W_CAPLO: word = cap[15:0];
            IDW_W_CAPHI: word = cap[31:16];
            IDW_W_MULT:  word = {7'h00, mult};
            IDW_W_LBALO: word = lba[15:0];
            IDW_W_LBAHI: word = lba[31:16];
            IDW_W_DMA:   word = {5'h00, sel_one, 5'h00, dma_sup};
            IDW_W_PIO:   word = {8'h00, pio};
            IDW_W_DMAMN: word = dma_times[15:0];
            IDW_W_DMARC: word = dma_times[31:16];
            IDW_W_PIOMN: word = pio_times[15:0];
            IDW_W_PIORD: word = pio_times[31:16];
            IDW_W_QDEP:  word = {11'h000, qdepth};
            IDW_W_MAJOR: word = {10'h000, major, 2'h0};
            IDW_W_MINOR: word = minor;
            IDW_W_FEAT:  word = feat & IDW_FEAT_MASK;
            default:     word = 16'h0000;
        endcase
    end

endmodule

/* File: verilog/idw_top.sv */
// Identify parameter block, words 50 to 82, with APB access.
// Overview of operation
// - Identify start sets busy, fills buffer, then sets data request and interrupt.
// - Reserved bits and words, including 50, 69-74, 76-79, read zero.
// - Word 53 bits 2..0 flag word 88, 64-70, 54-58 validity.
// - Words 54-56 current geometry; words 57-58 current capacity in sectors.
// - Word 59 bit 8 multiple valid; bits 7..0 sectors per interrupt.
// - Words 60-61 total user addressable sectors for LBA.
// - Word 63 bits 10..8 show the one selected multi-word DMA mode.
// - Word 63 bits 2..0 show supported multi-word DMA modes.
// - Word 64 bits 7..0 advanced PIO modes; upper byte zero.
// - Words 65 and 66 minimum and recommended DMA cycle times.
// - Words 67 and 68 PIO cycle times without and with flow control.
// - Word 75 bits 4..0 hold queue depth minus one.
// - Word 80 bits 5..2 flag major versions; others zero.
// - Word 81 holds the minor version number.
// - Host treats words 82-83 all zeros or ones as unsupported.
// - Word 82 bits 14,13,12,10,9 flag commands and protected area.
// - Word 82 bits 8..5 flag interrupts, look-ahead, write cache.
// - Word 82 bit 4 and obsolete bits 15, 11 read zero.
// - Word 82 bits 3..0 flag power, removable, security, self-monitor.
// Assumes an APB master on MCLK; the data register stands for the data port.
`timescale 1ns/1ns
module idw_top
    import idw_pkg::*;
#(
    parameter int NWORDS = IDW_NWORDS
)
(
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             BUSY,
    output logic             DRQ,
    output logic             INTRQ
);

    typedef enum logic [1:0] {
        IDW_IDLE,
        IDW_FILL,
        IDW_READY
    } idw_state_e;

    localparam int PW = $clog2(NWORDS + 1);
    localparam logic [PW-1:0] LAST_IDX = PW'(NWORDS - 1);

    // Configuration registers written by software
    logic [15:0] cyl_q;
    logic [15:0] head_q;
    logic [15:0] spt_q;
    logic [31:0] cap_q;
    logic [8:0]  mult_q;
    logic [31:0] lba_q;
    logic [31:0] dma_q;
    logic [7:0]  pio_q;
    logic [31:0] dmat_q;
    logic [31:0] piot_q;
    logic [4:0]  qdep_q;
    logic [31:0] ver_q;
    logic [15:0] feat_q;
    logic [2:0]  valid_q;

    // Sequencing state
    idw_state_e    state_q;
    idw_state_e    state_d;
    logic [PW-1:0] fill_q;
    logic [PW-1:0] rd_q;
    logic          intrq_q;
    logic          intrq_d;
    logic [31:0]   prdata_q;
    logic [15:0]   buf_q [NWORDS];
    logic [15:0]   fill_word;

    // Bus phase decode
    wire logic setup    = PSEL && !PENABLE;
    wire logic access   = PSEL && PENABLE;
    wire logic wr_acc   = access && PWRITE;
    wire logic rd_acc   = access && !PWRITE;
    wire logic hit_ctrl = PADDR == IDW_OFS_CTRL;
    wire logic hit_data = PADDR == IDW_OFS_DATA;
    wire logic mapped   = (PADDR[1:0] == 2'h0) && (PADDR <= IDW_OFS_VALID);

    // Start is ignored unless the sequencer is idle or holding a block
    wire logic start    = wr_acc && hit_ctrl && PWDATA[IDW_CTRL_START]
                          && (state_q != IDW_FILL);
    wire logic pop      = rd_acc && hit_data && (state_q == IDW_READY);
    wire logic last_pop = pop && (rd_q == LAST_IDX);
    wire logic fill_end = (state_q == IDW_FILL) && (fill_q == LAST_IDX);
    wire logic stat_rd  = rd_acc && hit_ctrl;

    // Word number being built during the fill
    wire logic [7:0] fill_num = IDW_FIRST_WORD + 8'(fill_q);

    idw_word_mux u_word (
        .word_num  (fill_num),
        .cyl       (cyl_q),
        .head      (head_q),
        .spt       (spt_q),
        .cap       (cap_q),
        .mult      (mult_q),
        .lba       (lba_q),
        .dma_sel   (dma_q[IDW_DMA_SEL_LSB +: IDW_DMA_SEL_W]),
        .dma_sup   (dma_q[IDW_DMA_SUP_W-1:0]),
        .pio       (pio_q),
        .dma_times (dmat_q),
        .pio_times (piot_q),
        .qdepth    (qdep_q),
        .major     (ver_q[IDW_MAJOR_LSB +: IDW_MAJOR_W]),
        .minor     (ver_q[31:16]),
        .feat      (feat_q),
        .valid     (valid_q),
        .word      (fill_word)
    );

    // Sequencer: busy while filling, data request until the last word leaves
    always_comb begin
        state_d = state_q;
        case (state_q)
            IDW_IDLE:  if (start) state_d = IDW_FILL;
            IDW_FILL:  if (fill_end) state_d = IDW_READY;
            IDW_READY: begin
                if (start)         state_d = IDW_FILL;
                else if (last_pop) state_d = IDW_IDLE;
            end
            default:   state_d = IDW_IDLE;
        endcase
    end

    // Interrupt: raised at end of fill, dropped by a status read, a data read or a start.
    // The raise wins so an end of fill is never lost to a clearing read.
    always_comb begin
        intrq_d = intrq_q;
        if (stat_rd || pop || start) intrq_d = 1'b0;
        if (fill_end)                intrq_d = 1'b1;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= IDW_IDLE;
            intrq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            intrq_q <= intrq_d;
        end
    end

    // Fill counter walks words in ascending order, one per cycle
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            fill_q <= '0;
        end else if (start) begin
            fill_q <= '0;
        end else if (state_q == IDW_FILL && !fill_end) begin
            fill_q <= fill_q + 1'b1;
        end
    end

    // Buffer array holds no reset; it is always written before it is read
    always_ff @(posedge MCLK) begin
        if (state_q == IDW_FILL) begin
            buf_q[fill_q] <= fill_word;
        end
    end

    // Read pointer: each data read while a block is ready hands out the next word
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_q <= '0;
        end else if (start) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= last_pop ? '0 : rd_q + 1'b1;
        end
    end

    // Write decode per register
    wire logic wr_cyl   = wr_acc && PADDR == IDW_OFS_CYL;
    wire logic wr_head  = wr_acc && PADDR == IDW_OFS_HEAD;
    wire logic wr_spt   = wr_acc && PADDR == IDW_OFS_SPT;
    wire logic wr_cap   = wr_acc && PADDR == IDW_OFS_CAP;
    wire logic wr_mult  = wr_acc && PADDR == IDW_OFS_MULT;
    wire logic wr_lba   = wr_acc && PADDR == IDW_OFS_LBA;
    wire logic wr_dma   = wr_acc && PADDR == IDW_OFS_DMA;
    wire logic wr_pio   = wr_acc && PADDR == IDW_OFS_PIO;
    wire logic wr_dmat  = wr_acc && PADDR == IDW_OFS_DMAT;
    wire logic wr_piot  = wr_acc && PADDR == IDW_OFS_PIOT;
    wire logic wr_qdep  = wr_acc && PADDR == IDW_OFS_QDEP;
    wire logic wr_ver   = wr_acc && PADDR == IDW_OFS_VER;
    wire logic wr_feat  = wr_acc && PADDR == IDW_OFS_FEAT;
    wire logic wr_valid = wr_acc && PADDR == IDW_OFS_VALID;

    // Geometry and capacity registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cyl_q  <= IDW_RST_ZERO[15:0];
            head_q <= IDW_RST_ZERO[15:0];
            spt_q  <= IDW_RST_ZERO[15:0];
            cap_q  <= IDW_RST_ZERO;
            lba_q  <= IDW_RST_ZERO;
        end else begin
            if (wr_cyl)  cyl_q  <= PWDATA[15:0];
            if (wr_head) head_q <= PWDATA[15:0];
            if (wr_spt)  spt_q  <= PWDATA[15:0];
            if (wr_cap)  cap_q  <= PWDATA;
            if (wr_lba)  lba_q  <= PWDATA;
        end
    end

    // Transfer mode and timing registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mult_q <= IDW_RST_ZERO[8:0];
            dma_q  <= IDW_RST_ZERO;
            pio_q  <= IDW_RST_ZERO[7:0];
            dmat_q <= IDW_RST_ZERO;
            piot_q <= IDW_RST_ZERO;
        end else begin
            if (wr_mult) mult_q <= PWDATA[8:0];
            if (wr_dma)  dma_q  <= PWDATA;
            if (wr_pio)  pio_q  <= PWDATA[7:0];
            if (wr_dmat) dmat_q <= PWDATA;
            if (wr_piot) piot_q <= PWDATA;
        end
    end

    // Queue, version, feature and validity registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            qdep_q  <= IDW_RST_ZERO[4:0];
            ver_q   <= IDW_RST_ZERO;
            feat_q  <= IDW_RST_ZERO[15:0];
            valid_q <= IDW_RST_ZERO[2:0];
        end else begin
            if (wr_qdep)  qdep_q  <= PWDATA[IDW_QDEP_W-1:0];
            if (wr_ver)   ver_q   <= PWDATA;
            if (wr_feat)  feat_q  <= PWDATA[15:0];
            if (wr_valid) valid_q <= PWDATA[IDW_VALID_W-1:0];
        end
    end

    // Status word shows the sequencer's own state
    wire logic [31:0] status = {29'h0, intrq_q,
                                state_q == IDW_READY, state_q == IDW_FILL};

    // Data read returns the word at the pointer only while a block is ready
    wire logic [31:0] data_word = (state_q == IDW_READY) ?
                                  {16'h0000, buf_q[rd_q]} : 32'h0000_0000;

    // Read mux; upper bits above fields narrower than a word read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (PADDR)
            IDW_OFS_CTRL:  rd_mux = status;
            IDW_OFS_DATA:  rd_mux = data_word;
            IDW_OFS_CYL:   rd_mux = {16'h0000, cyl_q};
            IDW_OFS_HEAD:  rd_mux = {16'h0000, head_q};
            IDW_OFS_SPT:   rd_mux = {16'h0000, spt_q};
            IDW_OFS_CAP:   rd_mux = cap_q;
            IDW_OFS_MULT:  rd_mux = {23'h000000, mult_q};
            IDW_OFS_LBA:   rd_mux = lba_q;
            IDW_OFS_DMA:   rd_mux = dma_q & 32'h0000_0707;
            IDW_OFS_PIO:   rd_mux = {24'h000000, pio_q};
            IDW_OFS_DMAT:  rd_mux = dmat_q;
            IDW_OFS_PIOT:  rd_mux = piot_q;
            IDW_OFS_QDEP:  rd_mux = {27'h0000000, qdep_q};
            IDW_OFS_VER:   rd_mux = ver_q & 32'hffff_003c;
            IDW_OFS_FEAT:  rd_mux = {16'h0000, feat_q & IDW_FEAT_MASK};
            IDW_OFS_VALID: rd_mux = {29'h00000000, valid_q};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup phase so it comes from a flop.
    // The pointer only moves at the access edge, so the captured word holds.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !PWRITE) begin
            prdata_q <= rd_mux;
        end
    end

    // Zero wait-state slave; unmapped or misaligned addresses raise an error
    assign PREADY  = 1'b1;
    assign PSLVERR = access && !mapped;
    assign PRDATA  = prdata_q;
    assign BUSY    = state_q == IDW_FILL;
    assign DRQ     = state_q == IDW_READY;
    assign INTRQ   = intrq_q;

endmodule

/* File: verif/idw_chk_sva.sv */
// Checker for the identify block: word contents on the data port and the fill handshake.
// Assumes it is bound to idw_top and sees only its ports.
`timescale 1ns/1ns
module idw_chk
    import idw_pkg::*;
#(
    parameter int NWORDS = IDW_NWORDS
)
(
    input wire logic        MCLK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        BUSY,
    input wire logic        DRQ,
    input wire logic        INTRQ
);
    logic [5:0] pop_cnt_q;
    logic [5:0] busy_cnt_q;
    // A data pop is a read access of the data port while the block is offered
    wire pop   = PSEL && PENABLE && !PWRITE && (PADDR == IDW_OFS_DATA) && DRQ;
    wire start = PSEL && PENABLE && PWRITE && (PADDR == IDW_OFS_CTRL) && PWDATA[0];

    // Word under read is 50 plus the pops done; cleared by a fill so restarts line up
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            pop_cnt_q  <= 6'h00;
            busy_cnt_q <= 6'h00;
        end else begin
            pop_cnt_q  <= BUSY ? 6'h00 : (pop ? pop_cnt_q + 6'h01 : pop_cnt_q);
            busy_cnt_q <= BUSY ? busy_cnt_q + 6'h01 : 6'h00;
        end
    end

    default clocking dflt_cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    AST_BUSY_DRQ_EXCL:
        assert property (!(BUSY && DRQ)) else $error("busy and data request together");
    AST_START_BUSY:
        assert property (start && !BUSY |=> BUSY) else $error("start did not raise busy");
    AST_FILL_LEN:
        assert property ($fell(BUSY) |-> busy_cnt_q == NWORDS && DRQ && INTRQ)
        else $error("fill length or end flags wrong");
    AST_RSVD_WORDS:
        assert property (pop && (pop_cnt_q inside {0, 1, 2, 12, [19:24], [26:29]}) |->
            PRDATA == 32'h0000_0000) else $error("reserved word not zero");
    AST_W53_BITS:
        assert property (pop && pop_cnt_q == 6'd3 |-> PRDATA[31:3] == '0)
        else $error("word 53 upper bits set");
    AST_W59_BITS:
        assert property (pop && pop_cnt_q == 6'd9 |-> PRDATA[31:9] == '0)
        else $error("word 59 upper bits set");
    AST_W63_BITS:
        assert property (pop && pop_cnt_q == 6'd13 |-> $onehot0(PRDATA[10:8]) &&
            PRDATA[31:11] == '0 && PRDATA[7:3] == '0) else $error("word 63 layout wrong");
    AST_W64_BITS:
        assert property (pop && pop_cnt_q == 6'd14 |-> PRDATA[31:8] == '0)
        else $error("word 64 upper byte set");
    AST_W75_BITS:
        assert property (pop && pop_cnt_q == 6'd25 |-> PRDATA[31:5] == '0)
        else $error("word 75 upper bits set");
    AST_W80_BITS:
        assert property (pop && pop_cnt_q == 6'd30 |-> PRDATA[31:6] == '0 && !PRDATA[0])
        else $error("word 80 reserved bits set");
    AST_W82_BITS:
        assert property (pop && pop_cnt_q == 6'd32 |-> !PRDATA[15] && !PRDATA[11] && !PRDATA[4])
        else $error("word 82 fixed zero bits set");
    AST_WORD_WIDTH:
        assert property (pop |-> PRDATA[31:16] == 16'h0000) else $error("data word wider than 16");
    AST_LAST_WORD:
        assert property ($fell(DRQ) && !BUSY |-> pop_cnt_q == NWORDS)
        else $error("data request ended at wrong word count");
endmodule

bind idw_top idw_chk #(.NWORDS(NWORDS)) chk_u (
    .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BUSY(BUSY), .DRQ(DRQ), .INTRQ(INTRQ)
);

/* File: verif/idw_host.sv */
// Host model: an APB master standing in for the controller that reads the block.
// Assumes one transfer at a time; a transfer waits for pready with no cycle count assumed.
`timescale 1ns/1ns
module idw_host
(
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Setup, then access held until pready is sampled high; an idle cycle follows
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep looking valid
        paddr   <= ~addr;
        pwdata  <= ~wdata;
    endtask

    // Both words all zeros or all ones means no command-set report
    function automatic logic cmdset_absent(input logic [15:0] w82, input logic [15:0] w83);
        return (w82 == 16'h0000 && w83 == 16'h0000) || (w82 == 16'hffff && w83 == 16'hffff);
    endfunction
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the identify block, words 50 to 82.
// Assumes the host model drives APB and the checker is bound to the design.
`timescale 1ns/1ns
module tb;
    import idw_pkg::*;
    logic        MCLK;
    logic        RST_B;
    wire         psel, penable, pwrite, pready, pslverr, busy, drq, intrq;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata, prdata;
    int          err_total;
    int          n_tests;
    logic [31:0] cfg [16];
    logic [31:0] rd;
    logic        er;

    idw_top dut_u (.MCLK(MCLK), .RST_B(RST_B), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BUSY(busy), .DRQ(drq), .INTRQ(intrq));
    idw_host host_u (.clk(MCLK), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // Free-running 100 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic rdreg(input logic [7:0] a);
        host_u.xfer(1'b0, a, 32'h0000_0000, rd, er);
    endtask

    // Expected word from the programmed fields; selected DMA mode shown one-hot, highest wins
    function automatic logic [15:0] exp_word(input int n);
        logic [2:0] sel;
        sel = cfg[8][10] ? 3'h4 : (cfg[8][9] ? 3'h2 : {2'h0, cfg[8][8]});
        case (n)
            53: return {13'h0, cfg[15][2:0]};
            54, 55, 56: return cfg[n - 52][15:0];
            57: return cfg[5][15:0];
            58: return cfg[5][31:16];
            59: return {7'h0, cfg[6][8:0]};
            60: return cfg[7][15:0];
            61: return cfg[7][31:16];
            63: return {5'h0, sel, 5'h0, cfg[8][2:0]};
            64: return {8'h0, cfg[9][7:0]};
            65, 66: return (n == 65) ? cfg[10][15:0] : cfg[10][31:16];
            67, 68: return (n == 67) ? cfg[11][15:0] : cfg[11][31:16];
            75: return {11'h0, cfg[12][4:0]};
            80: return {10'h0, cfg[13][5:2], 2'h0};
            81: return cfg[13][31:16];
            82: return cfg[14][15:0] & 16'h77ef;
            default: return 16'h0000;
        endcase
    endfunction

    // Start an identify and wait, bounded, for the block to be offered
    task automatic start_fill();
        wr(IDW_OFS_CTRL, 32'h0000_0001);
        @(negedge MCLK);
        check({31'h0, busy}, 32'h1);
        for (int i = 0; i < 100 && drq !== 1'b1; i++) @(negedge MCLK);
        check({29'h0, busy, drq, intrq}, 32'h3);
    endtask

    task automatic t_reset();
        check({29'h0, busy, drq, intrq}, 32'h0);
        for (int a = 0; a < 16; a++) begin
            rdreg(8'(a * 4));
            check(rd, 32'h0000_0000);
        end
        rdreg(8'h40);
        check({rd[30:0], er}, 32'h1);
    endtask

    task automatic t_identify();
        for (int i = 2; i < 16; i++) wr(8'(i * 4), cfg[i]);
        rdreg(IDW_OFS_FEAT);
        check(rd, 32'h0000_77ef);
        start_fill();
        for (int w = 50; w <= 82; w++) begin
            rdreg(IDW_OFS_DATA);
            check(rd, {16'h0, exp_word(w)});
        end
        check({31'h0, host_u.cmdset_absent(rd[15:0], 16'h0000)}, 32'h0);
        @(negedge MCLK);
        check({31'h0, drq}, 32'h0);
        rdreg(IDW_OFS_DATA);
        check(rd, 32'h0000_0000);
    endtask

    // Status read while offered, then a restart part-way through must begin at word 50 again
    task automatic t_status_restart();
        start_fill();
        rdreg(IDW_OFS_CTRL);
        check(rd, 32'h0000_0006);
        repeat (5) rdreg(IDW_OFS_DATA);
        start_fill();
        for (int w = 50; w <= 54; w++) begin
            rdreg(IDW_OFS_DATA);
            check(rd, {16'h0, exp_word(w)});
        end
    endtask

    // Each selected multi-word DMA mode with its matching supported set
    task automatic t_dma_modes();
        for (int k = 0; k < 3; k++) begin
            cfg[8] = {21'h0, 3'(3'b001 << k), 5'h0, 3'(3'b111 >> (2 - k))};
            wr(IDW_OFS_DMA, cfg[8]);
            start_fill();
            repeat (14) rdreg(IDW_OFS_DATA);
            check(rd, {16'h0, exp_word(63)});
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cut a hang short well beyond the expected six hundred or so cycles
    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    initial begin
        err_total = 0;
        n_tests   = 0;
        RST_B     = 1'b0;
        cfg = '{32'h0, 32'h0, 32'h0000_3fff, 32'h0000_0010, 32'h0000_003f, 32'h00fb_fc10,
                32'h0000_0110, 32'h0abc_def0, 32'h0000_0607, 32'h0000_0003, 32'h0078_0096,
                32'h00b4_0078, 32'h0000_001f, 32'h0017_003c, 32'h0000_ffff, 32'h0000_0007};
        repeat (4) @(posedge MCLK);
        RST_B <= 1'b1;
        t_reset();
        t_identify();
        t_status_restart();
        t_dma_modes();
        finish_test();
    end
endmodule
